// ### logic/ofs_output_function_selector.sv
// How it works
// [R1] each slot holds one function code and drives exactly that function's status
// [R2] reset defaults: slots 1..5 = 1,28,2,76,26; others and z-pin = 0
// [R3] slots 1 to 5 drive the five physical sequence output pins
// [R4] slots 6 to 21 go only into host communication data bits
// [R5] z-pin slot nonzero: z-pin shows that function instead of encoder z-phase
// [R6] codes include ready, in-position, alarms, alarm code, mode bits, input pass-through
// [R7] selections latch only on edges where powerup_load is high (reset loads the defaults); running mux keeps them
// [R8] one inversion bit per physical output 1..5, default no inversion
// [R9] separate bit inverts z-pin when used as function output
// [R10] code 0 means unassigned: output inactive, z-pin keeps encoder z-phase
`timescale 1ns/1ps
module ofs_output_function_selector
    import ofs_pkg::*;
(
    input  wire logic                     mclk,
    input  wire logic                     sys_rst,
    input  wire logic                     powerup_load,
    input  wire ofs_cfg_s                 cfg_in,
    input  wire logic                     servo_on_ready,
    input  wire logic                     in_position_flag,
    input  wire logic                     alarm_active,
    input  wire logic [4:0]               alarm_code,
    input  wire logic [7:0]               mode_bits,
    input  wire logic [4:0]               pass_inputs,
    input  wire ofs_func_t                other_status,
    input  wire logic                     zphase_enc,
    output logic [NUM_PINS-1:0]           seq_out_pins,
    output logic [NUM_COMM-1:0]           comm_out_bits,
    output logic                          zphase_pulse_pin,
    output ofs_cfg_s                      cfg_active
);

    // ***************************************************
    // status vector assembly
    // ***************************************************
    ofs_func_t func_vec;
    ofs_cfg_s  cfg_q;
    ofs_cfg_s  cfg_d;

    always_comb begin
        func_vec = other_status;
        func_vec[0] = 1'b0; // [R10]
        func_vec[FN_SERVO_RDY] = servo_on_ready; // [R6]
        func_vec[FN_IN_POS] = in_position_flag;
        func_vec[FN_ALARM_NO] = alarm_active;
        func_vec[FN_ALARM_NC] = ~alarm_active;
        for (int i = 0; i < 5; i++) begin
            func_vec[FN_ALM_CODE0 + i] = alarm_code[i];
            func_vec[FN_PASS_A + i] = pass_inputs[i];
        end
        for (int i = 0; i < 8; i++) begin
            func_vec[FN_MODE_BIT0 + i] = mode_bits[i];
        end
    end

    function automatic logic pick(input ofs_func_t v, input ofs_code_t c);
        pick = (c < ofs_code_t'(NUM_FUNCS)) ? v[c] : 1'b0; // [R1]
    endfunction

    // ***************************************************
    // power-up latch
    // ***************************************************
    ofs_cfg_s cfg_rst;
    always_comb begin
        cfg_rst.slot_sel = '0;
        cfg_rst.slot_sel[0] = RST_SLOT_1; // [R2]
        cfg_rst.slot_sel[1] = RST_SLOT_2;
        cfg_rst.slot_sel[2] = RST_SLOT_3;
        cfg_rst.slot_sel[3] = RST_SLOT_4;
        cfg_rst.slot_sel[4] = RST_SLOT_5;
        for (int i = 5; i < NUM_SLOTS; i++) begin
            cfg_rst.slot_sel[i] = RST_SLOT_HI;
        end
        cfg_rst.zpin_sel = RST_ZPIN;
        cfg_rst.inv = RST_INV;
        cfg_rst.zinv = RST_ZINV;
    end

    assign cfg_d = powerup_load ? cfg_in : cfg_q; // [R7]

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cfg_q <= cfg_rst;
        end else begin
            cfg_q <= cfg_d;
        end
    end

    assign cfg_active = cfg_q;

    // ***************************************************
    // output muxing
    // ***************************************************
    logic [NUM_PINS-1:0] pins_d;
    logic [NUM_COMM-1:0] comm_d;
    logic                zpin_d;
    wire                 zpin_used = (cfg_q.zpin_sel != FN_NONE);

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pins_d[i] = pick(func_vec, cfg_q.slot_sel[i]) ^ cfg_q.inv[i]; // [R3] [R8]
        end
        for (int i = 0; i < NUM_COMM; i++) begin
            comm_d[i] = pick(func_vec, cfg_q.slot_sel[NUM_PINS + i]); // [R4]
        end
        zpin_d = zpin_used ? (pick(func_vec, cfg_q.zpin_sel) ^ cfg_q.zinv) : zphase_enc; // [R5] [R9] [R10]
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seq_out_pins     <= '0;
            comm_out_bits    <= '0;
            zphase_pulse_pin <= 1'b0;
        end else begin
            seq_out_pins     <= pins_d;
            comm_out_bits    <= comm_d;
            zphase_pulse_pin <= zpin_d;
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    property p_slot1_follow;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) |-> seq_out_pins[0] == ($past(pick(func_vec, cfg_q.slot_sel[0])) ^ $past(cfg_q.inv[0]));
    endproperty
    a_slot1_follow: assert property (p_slot1_follow) else $error("slot 1 pin mismatch"); // [R1]

    // pins and data bits are registered, so checks look one edge back
    property p_reset_defaults;
        @(posedge mclk)
        sys_rst |=> cfg_q.slot_sel[0] == 7'h01 && cfg_q.slot_sel[1] == 7'h1c && cfg_q.slot_sel[2] == 7'h02
            && cfg_q.slot_sel[3] == 7'h4c && cfg_q.slot_sel[4] == 7'h1a && cfg_q.slot_sel[20:5] == '0
            && cfg_q.zpin_sel == 7'h00 && cfg_q.inv == 5'h00 && !cfg_q.zinv;
    endproperty
    a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset defaults"); // [R2]

    property p_pin5;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) |-> seq_out_pins[4] == $past(pins_d[4]);
    endproperty
    a_pin5: assert property (p_pin5) else $error("pin 5 not routed"); // [R3]

    property p_comm_last;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) |-> comm_out_bits[15] == $past(pick(func_vec, cfg_q.slot_sel[20]));
    endproperty
    a_comm_last: assert property (p_comm_last) else $error("slot 21 comm bit wrong"); // [R4]

    property p_zpin_func;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) && $past(zpin_used)
            |-> zphase_pulse_pin == ($past(pick(func_vec, cfg_q.zpin_sel)) ^ $past(cfg_q.zinv));
    endproperty
    a_zpin_func: assert property (p_zpin_func) else $error("z-pin function wrong"); // [R5] [R9]

    property p_alarm_nc;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) && $past(cfg_q.slot_sel[3]) == FN_ALARM_NC
            |-> seq_out_pins[3] == ($past(!alarm_active) ^ $past(cfg_q.inv[3]));
    endproperty
    a_alarm_nc: assert property (p_alarm_nc) else $error("alarm contacts not complementary"); // [R6]

    property p_hold;
        @(posedge mclk) disable iff (sys_rst)
        !powerup_load && !sys_rst |=> $stable(cfg_q);
    endproperty
    a_hold: assert property (p_hold) else $error("config changed without power-up"); // [R7]

    property p_zpin_idle;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) && !$past(zpin_used) |-> zphase_pulse_pin == $past(zphase_enc);
    endproperty
    a_zpin_idle: assert property (p_zpin_idle) else $error("z-pin lost encoder z-phase"); // [R10]

    property p_inv_pin2;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) && $past(cfg_q.slot_sel[1]) == FN_NONE |-> seq_out_pins[1] == $past(cfg_q.inv[1]);
    endproperty
    a_inv_pin2: assert property (p_inv_pin2) else $error("inversion of idle pin 2 wrong"); // [R8]

    property p_reset_outputs;
        @(posedge mclk)
        sys_rst |=> seq_out_pins == '0 && comm_out_bits == '0 && !zphase_pulse_pin;
    endproperty
    a_reset_outputs: assert property (p_reset_outputs) else $error("outputs not cleared by reset"); // [R2]

    property p_load_take;
        @(posedge mclk) disable iff (sys_rst)
        powerup_load |=> cfg_q == $past(cfg_in);
    endproperty
    a_load_take: assert property (p_load_take) else $error("power-up selections not latched"); // [R7]

    property p_ready_pin1;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) && $past(cfg_q.slot_sel[0]) == FN_SERVO_RDY
            |-> seq_out_pins[0] == ($past(servo_on_ready) ^ $past(cfg_q.inv[0]));
    endproperty
    a_ready_pin1: assert property (p_ready_pin1) else $error("servo-on ready not on pin 1"); // [R6]

    property p_comm_unassigned;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) && $past(cfg_q.slot_sel[5]) == FN_NONE |-> !comm_out_bits[0];
    endproperty
    a_comm_unassigned: assert property (p_comm_unassigned) else $error("unassigned slot 6 bit active"); // [R10]

    property p_code_range;
        @(posedge mclk) disable iff (sys_rst)
        $past(!sys_rst) && $past(cfg_q.slot_sel[19]) >= ofs_code_t'(NUM_FUNCS) |-> !comm_out_bits[14];
    endproperty
    a_code_range: assert property (p_code_range) else $error("undefined code drives slot 20 bit"); // [R1]

    // main scenarios
    c_load:     cover property (@(posedge mclk) disable iff (sys_rst) powerup_load);
    c_zfunc:    cover property (@(posedge mclk) disable iff (sys_rst) zpin_used);
    c_invert:   cover property (@(posedge mclk) disable iff (sys_rst) cfg_q.inv != 5'h00);
    c_zidle:    cover property (@(posedge mclk) disable iff (sys_rst) !zpin_used && zphase_enc);
    c_unmapped: cover property (@(posedge mclk) disable iff (sys_rst) cfg_q.slot_sel[19] >= ofs_code_t'(NUM_FUNCS));

endmodule

// ### logic/ofs_pkg.sv
package ofs_pkg;

    localparam int unsigned NUM_SLOTS  = 21;
    localparam int unsigned NUM_PINS   = 5;
    localparam int unsigned NUM_FUNCS  = 96;
    localparam int unsigned NUM_COMM   = 16;

    typedef logic [6:0] ofs_code_t;

    // function codes
    localparam ofs_code_t FN_NONE       = 7'h00;
    localparam ofs_code_t FN_SERVO_RDY  = 7'h01;
    localparam ofs_code_t FN_IN_POS     = 7'h02;
    localparam ofs_code_t FN_ALARM_NO   = 7'h10;
    localparam ofs_code_t FN_CTRL_RDY   = 7'h1c;
    localparam ofs_code_t FN_TRQ_LIMIT  = 7'h1a;
    localparam ofs_code_t FN_ALM_CODE0  = 7'h20;
    localparam ofs_code_t FN_MODE_BIT0  = 7'h3c;
    localparam ofs_code_t FN_ALARM_NC   = 7'h4c;
    localparam ofs_code_t FN_PASS_A     = 7'h5b;

    // reset values of the slot selections
    localparam ofs_code_t RST_SLOT_1    = FN_SERVO_RDY;
    localparam ofs_code_t RST_SLOT_2    = FN_CTRL_RDY;
    localparam ofs_code_t RST_SLOT_3    = FN_IN_POS;
    localparam ofs_code_t RST_SLOT_4    = FN_ALARM_NC;
    localparam ofs_code_t RST_SLOT_5    = FN_TRQ_LIMIT;
    localparam ofs_code_t RST_SLOT_HI   = FN_NONE;
    localparam ofs_code_t RST_ZPIN      = FN_NONE;
    localparam logic [4:0] RST_INV      = 5'h00;
    localparam logic       RST_ZINV     = 1'b0;

    // latched configuration snapshot
    typedef struct packed {
        ofs_code_t [NUM_SLOTS-1:0] slot_sel;
        ofs_code_t                 zpin_sel;
        logic [NUM_PINS-1:0]       inv;
        logic                      zinv;
    } ofs_cfg_s;

    // status functions in, indexed by function code
    typedef logic [NUM_FUNCS-1:0] ofs_func_t;

endpackage

// ### test/ofs_host_model.sv
`timescale 1ns/1ps
// host side: captures pin levels and communication data bits each rising edge
module ofs_host_model
    import ofs_pkg::*;
(
    input  wire logic                         mclk,
    input  wire logic [NUM_PINS-1:0]          pins,
    input  wire logic [NUM_COMM-1:0]          comm,
    output logic [NUM_COMM+NUM_PINS-1:0]      rx_q
);
    always_ff @(posedge mclk) rx_q <= {comm, pins};
endmodule

// ### test/tb.sv
`timescale 1ns/1ps
module tb
    import ofs_pkg::*;
;
    logic                mclk = 1'h0, sys_rst = 1'h1, ld = 1'h0;
    logic                rdy = 1'h0, inp = 1'h0, alm = 1'h0, zenc = 1'h0, zp;
    logic [4:0]          acode = '0, pass = '0;
    logic [7:0]          mode = '0;
    ofs_func_t           oth = '0;
    ofs_cfg_s            cfg = '0, act, ec_cfg;
    logic [NUM_PINS-1:0] pins;
    logic [NUM_COMM-1:0] comm;
    logic [NUM_COMM+NUM_PINS-1:0] host_rx;
    int                  failures = 0, check_count = 0;
    localparam ofs_code_t codes[22] = '{7'h01, 7'h02, 7'h10, 7'h4c, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24, 7'h3c,
        7'h3d, 7'h3e, 7'h3f, 7'h40, 7'h41, 7'h42, 7'h43, 7'h5b, 7'h5c, 7'h5d, 7'h5e, 7'h5f};
    always #12.5 mclk = ~mclk;
    ofs_output_function_selector i_ofs_output_function_selector (.mclk(mclk), .sys_rst(sys_rst),
        .powerup_load(ld), .cfg_in(cfg), .servo_on_ready(rdy), .in_position_flag(inp), .alarm_active(alm),
        .alarm_code(acode), .mode_bits(mode), .pass_inputs(pass), .other_status(oth), .zphase_enc(zenc),
        .seq_out_pins(pins), .comm_out_bits(comm), .zphase_pulse_pin(zp), .cfg_active(act));
    ofs_host_model i_ofs_host_model (.mclk(mclk), .pins(pins), .comm(comm), .rx_q(host_rx));
    // ********************
    // checking helpers
    // ********************
    task automatic chk(input logic [$bits(ofs_cfg_s)-1:0] seen, exp, input string m);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    function automatic logic st(ofs_code_t c);
        if (c == 7'h01) return rdy;
        if (c == 7'h02) return inp;
        if (c == 7'h10) return alm;
        if (c == 7'h4c) return !alm;
        if (c inside {[7'h20:7'h24]}) return acode[c-7'h20];
        if (c inside {[7'h3c:7'h43]}) return mode[c-7'h3c];
        if (c inside {[7'h5b:7'h5f]}) return pass[c-7'h5b];
        if (c == 7'h00 || c >= 7'h60) return 1'h0;
        return oth[c];
    endfunction
    task automatic conclude();
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ********************
    // scenarios
    // ********************
    task automatic do_reset();
        sys_rst = 1'h1;
        repeat (5) @(negedge mclk);
        chk({pins, comm, zp}, '0, "outputs in reset");
        sys_rst = 1'h0;
        ec_cfg = '0;
        ec_cfg.slot_sel[0] = 7'h01;
        ec_cfg.slot_sel[1] = 7'h1c;
        ec_cfg.slot_sel[2] = 7'h02;
        ec_cfg.slot_sel[3] = 7'h4c;
        ec_cfg.slot_sel[4] = 7'h1a;
    endtask
    task automatic run_vec(input int p);
        logic [NUM_PINS-1:0] ep;
        logic [NUM_COMM-1:0] ec;
        {rdy, inp, alm, zenc} = 4'(p);
        acode = 5'(p * 7);
        mode = 8'(p * 91);
        pass = 5'(p * 11);
        oth = {3{32'(p * 32'h9e3779b9)}};
        @(negedge mclk);
        for (int i = 0; i < NUM_PINS; i++) ep[i] = st(ec_cfg.slot_sel[i]) ^ ec_cfg.inv[i];
        for (int i = 0; i < NUM_COMM; i++) ec[i] = st(ec_cfg.slot_sel[NUM_PINS+i]);
        chk(pins, ep, "pin outputs");
        chk(comm, ec, "comm bits");
        chk(zp, (ec_cfg.zpin_sel != 0) ? st(ec_cfg.zpin_sel) ^ ec_cfg.zinv : zenc, "z pin");
        chk(act, ec_cfg, "active config");
        @(negedge mclk);
        chk(host_rx, {ec, ep}, "host capture");
    endtask
    task automatic load(input ofs_cfg_s c, input logic go);
        cfg = c;
        ld = go;
        @(negedge mclk);
        ld = 1'h0;
        if (go) ec_cfg = c;
        @(negedge mclk);
    endtask
    initial begin
        ofs_cfg_s a, b;
        for (int k = 0; k < NUM_SLOTS; k++) a.slot_sel[k] = codes[k];
        for (int k = 0; k < NUM_SLOTS; k++) b.slot_sel[k] = 7'(k * 6);
        b.slot_sel[1] = 7'h00;
        {a.zpin_sel, a.inv, a.zinv} = {codes[21], 5'h15, 1'h1};
        {b.zpin_sel, b.inv, b.zinv} = {7'h00, 5'h1f, 1'h1};
        do_reset();
        for (int p = 0; p < 4; p++) run_vec(p);
        load(a, 1'h1);
        for (int p = 0; p < 16; p++) run_vec(p);
        load(b, 1'h0);
        for (int p = 0; p < 2; p++) run_vec(p);
        load(b, 1'h1);
        for (int p = 0; p < 16; p++) run_vec(p);
        do_reset();
        for (int p = 0; p < 2; p++) run_vec(p);
        conclude();
    end
    initial begin
        #(25 * 3000);
        failures++;
        conclude();
    end
endmodule
